/* File: logic/ctm_timer.sv */
// Compact ten-bit timer with compare A/P, PWM and APB register access
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module ctm_timer #(
   parameter int CNT_W = 10
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             timer_out,
   output logic             timer_out_en,
   output logic             compare_a_flag,
   output logic             compare_p_flag
);
   // ***************************************
   // Reset release
   // ***************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ***************************************
   // Registers
   // ***************************************
   logic [7:0]       ctrl0;
   logic [7:0]       ctrl1;
   logic [7:0]       clkdiv;
   logic [CNT_W-1:0] compare_a_value;
   logic [CNT_W-1:0] count;
   logic [7:0]       div_cnt;
   logic             enable_d;
   logic             pin_q;

   wire              wr_en = psel & penable & pwrite;
   wire              rd_en = psel & penable & ~pwrite;
   wire              addr_ok = (paddr == ctm_pkg::ADDR_CTRL0) | (paddr == ctm_pkg::ADDR_CTRL1)
                     | (paddr == ctm_pkg::ADDR_CNT_LO) | (paddr == ctm_pkg::ADDR_CNT_HI)
                     | (paddr == ctm_pkg::ADDR_CMPA_LO) | (paddr == ctm_pkg::ADDR_CMPA_HI)
                     | (paddr == ctm_pkg::ADDR_STATUS) | (paddr == ctm_pkg::ADDR_CLKDIV);

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // ***************************************
   // Field decode
   // ***************************************
   wire              counter_pause    = ctrl0[ctm_pkg::CTRL0_PAUSE];
   wire              module_enable    = ctrl0[ctm_pkg::CTRL0_ENABLE];
   wire [2:0]        compare_p_value  = ctrl0[ctm_pkg::CTRL0_P_MSB -: 3];
   wire [1:0]        mode_sel         = ctrl1[ctm_pkg::CTRL1_MODE_LSB +: 2];
   wire [1:0]        pin_function     = ctrl1[ctm_pkg::CTRL1_PIN_LSB +: 2];
   wire              output_control   = ctrl1[ctm_pkg::CTRL1_OC];
   wire              output_polarity  = ctrl1[ctm_pkg::CTRL1_POL];
   wire              period_duty_swap = ctrl1[ctm_pkg::CTRL1_SWAP];
   wire              clear_select     = ctrl1[ctm_pkg::CTRL1_CCLR];
   wire              is_pwm = (mode_sel == ctm_pkg::CTM_MODE_PWM);
   wire              is_cmp = (mode_sel == ctm_pkg::CTM_MODE_COMPARE);
   wire              enable_rise = module_enable & ~enable_d;

   // ***************************************
   // Tick divider: one-cycle enable every clkdiv+1 cycles
   // ***************************************
   wire              tick = (div_cnt == clkdiv);
   wire              run  = module_enable & ~counter_pause;
   wire              step = run & tick;

   // ***************************************
   // Comparators
   // ***************************************
   // P against top three bits
   wire              p_match  = (count[CNT_W-1 -: 3] == compare_p_value);
   wire              a_match  = (count == compare_a_value);
   wire              at_max   = (count == ctm_pkg::CNT_MAX);
   // P zero clears at overflow only
   wire              p_event  = (compare_p_value == 3'h0) ? at_max : p_match;
   // A zero means overflow, no A flag
   wire              a_event  = (compare_a_value != '0) & a_match;
   wire              a_flag_ev;
   wire              p_flag_ev;
   wire              clr_hit;
   // Counter about to reach the period value; clearing here keeps the period exact
   wire              pwm_end;
   // period comparator clears in PWM, ignoring clear select
   wire              pwm_clr  = pwm_end;
   // clear selection in compare and timer modes
   wire              cmp_clr  = clear_select ? (a_event | at_max) : p_event;
   assign clr_hit   = is_pwm ? pwm_clr : cmp_clr;
   // period role flags at period end, duty role on its match
   wire              a_hit    = (is_pwm & period_duty_swap) ? pwm_end : a_event;
   wire              p_hit    = (is_pwm & ~period_duty_swap) ? pwm_end : p_event;
   // flags in all modes, on a counting step
   assign a_flag_ev = step & a_hit;
   // no P flag with clear select high outside PWM
   assign p_flag_ev = step & p_hit & (is_pwm | ~clear_select);

   // ***************************************
   // PWM duty
   // ***************************************
   // period and duty in counts
   wire [CNT_W:0]    p_len    = (compare_p_value == 3'h0) ? 11'h400
                                : {1'b0, compare_p_value, 7'h00};
   wire [CNT_W:0]    a_len    = {1'b0, compare_a_value};
   // swap exchanges period and duty roles
   wire [CNT_W:0]    duty_len   = period_duty_swap ? p_len : a_len;
   wire [CNT_W:0]    period_len = period_duty_swap ? a_len : p_len;
   assign pwm_end = (({1'b0, count} + 11'h001) == period_len);
   // duty at or above period is full active
   wire              pwm_active = (duty_len >= period_len) | ({1'b0, count} < duty_len);
   wire              pwm_level = (pin_function == ctm_pkg::PIN_NONE) ? 1'b0 :
                                 (pin_function == ctm_pkg::PIN_LOW) ? 1'b1 : pwm_active;
   wire              pwm_pin   = output_control ? pwm_level : ~pwm_level;

   // ***************************************
   // Counter and divider
   // ***************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt  <= 8'h00;
         count    <= '0;
         enable_d <= 1'b0;
      end else begin
         enable_d <= module_enable;
         div_cnt  <= (tick | ~run) ? 8'h00 : div_cnt + 8'h01;
         // enable rise zeroes counter, pause holds
         if (enable_rise) begin
            count <= '0;
         end else if (step) begin
            // counting continues in all pin functions; wrap
            count <= clr_hit ? '0 : count + 1'b1;
         end
      end
   end

   // ***************************************
   // Compare pin
   // ***************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
      end else if (enable_rise) begin
         pin_q <= output_control;
      end else if (is_cmp & a_flag_ev) begin
         // pin action on A match only
         unique case (pin_function)
            ctm_pkg::PIN_NONE:   pin_q <= pin_q;
            ctm_pkg::PIN_LOW:    pin_q <= 1'b0;
            ctm_pkg::PIN_HIGH:   pin_q <= 1'b1;
            ctm_pkg::PIN_TOGGLE: pin_q <= ~pin_q;
         endcase
      end
   end

   // Output flop; timer mode releases the pin for other functions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_out    <= 1'b0;
         timer_out_en <= 1'b0;
      end else begin
         // no pin drive in timer mode
         timer_out_en <= is_cmp | is_pwm;
         timer_out    <= (is_pwm ? pwm_pin : pin_q) ^ output_polarity;
      end
   end

   // ***************************************
   // Register writes and flags
   // ***************************************
   wire wr_status = wr_en & (paddr == ctm_pkg::ADDR_STATUS);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0           <= ctm_pkg::CTRL_RESET;
         ctrl1           <= ctm_pkg::CTRL_RESET;
         clkdiv          <= ctm_pkg::CLKDIV_RESET;
         compare_a_value <= '0;
         compare_a_flag  <= 1'b0;
         compare_p_flag  <= 1'b0;
      end else begin
         if (wr_en && paddr == ctm_pkg::ADDR_CTRL0) ctrl0 <= pwdata[7:0];
         if (wr_en && paddr == ctm_pkg::ADDR_CTRL1) ctrl1 <= pwdata[7:0];
         if (wr_en && paddr == ctm_pkg::ADDR_CLKDIV) clkdiv <= pwdata[7:0];
         if (wr_en && paddr == ctm_pkg::ADDR_CMPA_LO) compare_a_value[7:0] <= pwdata[7:0];
         if (wr_en && paddr == ctm_pkg::ADDR_CMPA_HI) compare_a_value[9:8] <= pwdata[1:0];
         // Set wins over a write-one-to-clear in the same cycle
         compare_a_flag <= a_flag_ev |
                           (compare_a_flag & ~(wr_status & pwdata[ctm_pkg::STAT_A_FLAG]));
         compare_p_flag <= p_flag_ev |
                           (compare_p_flag & ~(wr_status & pwdata[ctm_pkg::STAT_P_FLAG]));
      end
   end

   // ***************************************
   // Read data
   // ***************************************
   logic [7:0] rd_byte;
   always_comb begin
      unique case (paddr)
         ctm_pkg::ADDR_CTRL0:   rd_byte = ctrl0;
         ctm_pkg::ADDR_CTRL1:   rd_byte = ctrl1;
         ctm_pkg::ADDR_CNT_LO:  rd_byte = count[7:0];
         ctm_pkg::ADDR_CNT_HI:  rd_byte = {6'h00, count[9:8]};
         ctm_pkg::ADDR_CMPA_LO: rd_byte = compare_a_value[7:0];
         ctm_pkg::ADDR_CMPA_HI: rd_byte = {6'h00, compare_a_value[9:8]};
         ctm_pkg::ADDR_STATUS:  rd_byte = {6'h00, compare_p_flag, compare_a_flag};
         ctm_pkg::ADDR_CLKDIV:  rd_byte = clkdiv;
         default:               rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         // Loaded in setup so the data stand at the access edge
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      (step && at_max && !enable_rise) |=> (count == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not clear at 3FF");

   property p_enable_zero;
      @(posedge clk) disable iff (!rst_n)
      enable_rise |=> (count == '0) && (pin_q == $past(output_control));
   endproperty
   a_enable_zero: assert property (p_enable_zero) else $error("enable rise did not reset");

   property p_pause_hold;
      @(posedge clk) disable iff (!rst_n)
      (!run && !enable_rise) |=> $stable(count);
   endproperty
   a_pause_hold: assert property (p_pause_hold) else $error("counter moved while stopped");

   property p_no_pflag;
      @(posedge clk) disable iff (!rst_n)
      (!is_pwm && clear_select) |-> !p_flag_ev;
   endproperty
   a_no_pflag: assert property (p_no_pflag) else $error("P flag with clear select high");

   property p_a_zero;
      @(posedge clk) disable iff (!rst_n)
      (compare_a_value == '0) |-> !a_flag_ev;
   endproperty
   a_a_zero: assert property (p_a_zero) else $error("A flag with compare A zero");

   property p_flag_set;
      @(posedge clk) disable iff (!rst_n)
      a_flag_ev |=> compare_a_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("A flag not set on match");

   property p_timer_pin;
      @(posedge clk) disable iff (!rst_n)
      (mode_sel == ctm_pkg::CTM_MODE_TIMER) |=> !timer_out_en;
   endproperty
   a_timer_pin: assert property (p_timer_pin) else $error("pin driven in timer mode");

   property p_pwm_clear;
      @(posedge clk) disable iff (!rst_n)
      (is_pwm && step && !period_duty_swap && compare_p_value != 3'h0
       && (count + 10'h001) == {compare_p_value, 7'h00} && !enable_rise) |=> (count == '0);
   endproperty
   a_pwm_clear: assert property (p_pwm_clear) else $error("PWM period clear missing");

   property p_cnt_hi;
      @(posedge clk) disable iff (!rst_n)
      rd_en |=> (prdata[31:10] == 22'h00_0000);
   endproperty
   a_cnt_hi: assert property (p_cnt_hi) else $error("upper read bits not zero");

   property p_count_step;
      @(posedge clk) disable iff (!rst_n)
      (step && !clr_hit && !enable_rise) |=> (count == $past(count) + 10'h001);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step");

   property p_cmp_p_clear;
      @(posedge clk) disable iff (!rst_n)
      (!is_pwm && step && !clear_select && compare_p_value != 3'h0
       && count[CNT_W-1 -: 3] == compare_p_value && !enable_rise) |=> (count == '0);
   endproperty
   a_cmp_p_clear: assert property (p_cmp_p_clear) else $error("P match did not clear");

   property p_swap_clear;
      @(posedge clk) disable iff (!rst_n)
      (is_pwm && step && period_duty_swap && compare_a_value != '0
       && (count + 10'h001) == compare_a_value && !enable_rise) |=> (count == '0);
   endproperty
   a_swap_clear: assert property (p_swap_clear) else $error("A period clear missing");

   property p_cmp_pin_hold;
      @(posedge clk) disable iff (!rst_n)
      (is_cmp && !a_flag_ev && !enable_rise) |=> $stable(pin_q);
   endproperty
   a_cmp_pin_hold: assert property (p_cmp_pin_hold) else $error("pin moved, no A match");

   property p_pwm_forced;
      @(posedge clk) disable iff (!rst_n)
      (is_pwm && pin_function == ctm_pkg::PIN_NONE)
      |=> (timer_out == (!$past(output_control) ^ $past(output_polarity)));
   endproperty
   a_pwm_forced: assert property (p_pwm_forced) else $error("forced level wrong");

   property p_full_duty;
      @(posedge clk) disable iff (!rst_n)
      (is_pwm && pin_function == ctm_pkg::PIN_HIGH && duty_len >= period_len)
      |=> (timer_out == ($past(output_control) ^ $past(output_polarity)));
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("full duty not active");

   property p_pflag_set;
      @(posedge clk) disable iff (!rst_n)
      p_flag_ev |=> compare_p_flag;
   endproperty
   a_pflag_set: assert property (p_pflag_set) else $error("P flag not set on match");

   property p_pin_drive;
      @(posedge clk) disable iff (!rst_n)
      (is_cmp || is_pwm) |=> timer_out_en;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

   c_pwm_run:   cover property (@(posedge clk) disable iff (!rst_n) is_pwm && step && clr_hit);
   c_toggle:    cover property (@(posedge clk) disable iff (!rst_n) is_cmp && a_flag_ev);
   c_pflag:     cover property (@(posedge clk) disable iff (!rst_n) p_flag_ev);
   c_full_duty: cover property (@(posedge clk) disable iff (!rst_n)
                                is_pwm && duty_len >= period_len);
   c_swap_end:  cover property (@(posedge clk) disable iff (!rst_n)
                                is_pwm && period_duty_swap && pwm_end);
endmodule

/* File: logic/ctm_pkg.sv */
// Package: register map, fields and constants of the compact timer
package ctm_pkg;
   // ***************************************
   // Register byte addresses
   // ***************************************
   localparam logic [11:0] ADDR_CTRL0    = 12'h000;
   localparam logic [11:0] ADDR_CTRL1    = 12'h004;
   localparam logic [11:0] ADDR_CNT_LO   = 12'h008;
   localparam logic [11:0] ADDR_CNT_HI   = 12'h00C;
   localparam logic [11:0] ADDR_CMPA_LO  = 12'h010;
   localparam logic [11:0] ADDR_CMPA_HI  = 12'h014;
   localparam logic [11:0] ADDR_STATUS   = 12'h018;
   localparam logic [11:0] ADDR_CLKDIV   = 12'h01C;
   // ***************************************
   // Control 0 fields
   // ***************************************
   localparam int CTRL0_PAUSE  = 7;
   localparam int CTRL0_ENABLE = 3;
   localparam int CTRL0_P_MSB  = 2;
   // ***************************************
   // Control 1 fields
   // ***************************************
   localparam int CTRL1_MODE_LSB = 6;
   localparam int CTRL1_PIN_LSB  = 4;
   localparam int CTRL1_OC       = 3;
   localparam int CTRL1_POL      = 2;
   localparam int CTRL1_SWAP     = 1;
   localparam int CTRL1_CCLR     = 0;
   // ***************************************
   // Status fields, reset values, counts
   // ***************************************
   localparam int STAT_A_FLAG = 0;
   localparam int STAT_P_FLAG = 1;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  CLKDIV_RESET = 8'h00;
   localparam logic [9:0]  CNT_MAX      = 10'h3FF;
   localparam int          P_SHIFT      = 7;
   typedef enum logic [1:0] {
      CTM_MODE_COMPARE = 2'b00,
      CTM_MODE_UNDEF   = 2'b01,
      CTM_MODE_PWM     = 2'b10,
      CTM_MODE_TIMER   = 2'b11
   } ctm_mode_t;
   localparam logic [1:0] PIN_NONE   = 2'b00;
   localparam logic [1:0] PIN_LOW    = 2'b01;
   localparam logic [1:0] PIN_HIGH   = 2'b10;
   localparam logic [1:0] PIN_TOGGLE = 2'b11;
endpackage

/* File: testbench/ctm_pin_load.sv */
// Load model on the timer pin: counts high samples and rising edges
`timescale 1ns/1ps
module ctm_pin_load (
   input  wire logic        clk,
   input  wire logic        pin,
   input  wire logic        pin_en,
   input  wire logic        clr,
   output logic [15:0]      high_cnt,
   output logic [7:0]       rise_cnt
);
   // Pull-down on the board: an undriven pin reads low
   wire        level = pin_en & pin;
   logic       last;
   always_ff @(posedge clk) begin
      last <= level;
      if (clr) begin
         high_cnt <= 16'h0000;
         rise_cnt <= 8'h00;
      end else begin
         high_cnt <= high_cnt + {15'h0000, level};
         rise_cnt <= rise_cnt + {7'h00, level & ~last};
      end
   end
endmodule

/* File: testbench/tb_top.sv */
// Testbench for the compact timer: registers, compare, timer and PWM modes
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        t_out;
   logic        t_en;
   logic        a_flag;
   logic        p_flag;
   logic        clr = 1'b1;
   logic [15:0] high_cnt;
   logic [7:0]  rise_cnt;
   logic [31:0] rd;
   logic        err;
   int          miscompares = 0;
   int          checked = 0;
   always #20 clk = ~clk;
   ctm_timer i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_out(t_out), .timer_out_en(t_en), .compare_a_flag(a_flag),
      .compare_p_flag(p_flag));
   ctm_pin_load i_load (.clk(clk), .pin(t_out), .pin_en(t_en), .clr(clr),
      .high_cnt(high_cnt), .rise_cnt(rise_cnt));
   // ***************************************
   // Bus and compare helpers
   // ***************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      check("pready", {31'h0, pready}, 32'h1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Mode changes only while stopped, so the block is switched off first
   task automatic start(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 8'h00);
      apb(1'b1, ctm_pkg::ADDR_CTRL1, c1);
      apb(1'b1, ctm_pkg::ADDR_CMPA_LO, a[7:0]);
      apb(1'b1, ctm_pkg::ADDR_CMPA_HI, {6'h00, a[9:8]});
      apb(1'b1, ctm_pkg::ADDR_STATUS, 8'h03);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, c0);
   endtask
   task automatic duty(input int n, input logic [15:0] exp, input logic [7:0] rises);
      repeat (4) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
      check("pwm high cycles", {16'h0000, high_cnt}, {16'h0000, exp});
      check("pwm rising edges", {24'h000000, rise_cnt}, {24'h000000, rises});
   endtask
   // ***************************************
   // Scenarios
   // ***************************************
   task automatic t_regs();
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      check("count low reset", rd, 32'h0);
      apb(1'b0, ctm_pkg::ADDR_CMPA_HI, 8'h00);
      check("compare high reset", rd, 32'h0);
      apb(1'b1, ctm_pkg::ADDR_CMPA_HI, 8'hFF);
      apb(1'b0, ctm_pkg::ADDR_CMPA_HI, 8'h00);
      check("compare high bits", rd, 32'h3);
      apb(1'b1, ctm_pkg::ADDR_CMPA_LO, 8'hA5);
      apb(1'b0, ctm_pkg::ADDR_CMPA_LO, 8'h00);
      check("compare low", rd, 32'hA5);
      apb(1'b1, ctm_pkg::ADDR_CNT_LO, 8'h55);
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      check("count read only", rd, 32'h0);
      apb(1'b0, 12'h040, 8'h00);
      check("unmapped error", {31'h0, err}, 32'h1);
   endtask
   task automatic t_pinfn();
      logic [7:0] c1s [3] = '{8'h19, 8'h21, 8'h09};
      logic       exp [3] = '{1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 3; i++) begin
         start(c1s[i], 10'h00A, 8'h08);
         repeat (30) @(posedge clk);
         check("pin function level", {31'h0, t_out}, {31'h0, exp[i]});
      end
   endtask
   task automatic t_cmp_a();
      start(8'h31, 10'h12C, 8'h09);
      repeat (20) @(posedge clk);
      check("pin initial low", {31'h0, t_out}, 32'h0);
      check("pin enabled", {31'h0, t_en}, 32'h1);
      repeat (310) @(posedge clk);
      check("a flag", {31'h0, a_flag}, 32'h1);
      check("no p flag", {31'h0, p_flag}, 32'h0);
      check("pin toggled", {31'h0, t_out}, 32'h1);
      apb(1'b0, ctm_pkg::ADDR_CNT_HI, 8'h00);
      check("count cleared by a", rd, 32'h0);
   endtask
   task automatic t_clear_p();
      start(8'h00, 10'h00A, 8'h09);
      repeat (150) @(posedge clk);
      check("a flag", {31'h0, a_flag}, 32'h1);
      check("p flag", {31'h0, p_flag}, 32'h1);
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      check("count cleared at 128", rd >> 7, 32'h0);
   endtask
   task automatic t_timer();
      start(8'hF1, 10'h000, 8'h08);
      repeat (300) @(posedge clk);
      check("no a flag at zero", {31'h0, a_flag}, 32'h0);
      check("pin released", {31'h0, t_en}, 32'h0);
      apb(1'b0, ctm_pkg::ADDR_CNT_HI, 8'h00);
      check("count past 255", rd, 32'h1);
   endtask
   task automatic t_pwm();
      start(8'hA8, 10'h020, 8'h09);
      duty(256, 16'h0040, 8'h02);
      start(8'hAC, 10'h020, 8'h09);
      duty(256, 16'h00C0, 8'h02);
      start(8'h98, 10'h020, 8'h09);
      duty(256, 16'h0100, 8'h00);
      check("a flag while forced", {31'h0, a_flag}, 32'h1);
      check("p flag while forced", {31'h0, p_flag}, 32'h1);
      start(8'h88, 10'h020, 8'h09);
      duty(256, 16'h0000, 8'h00);
      start(8'hAA, 10'h064, 8'h09);
      duty(256, 16'h0100, 8'h00);
   endtask
   task automatic t_pause();
      logic [31:0] held;
      start(8'h00, 10'h000, 8'h08);
      repeat (40) @(posedge clk);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 8'h88);
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      held = rd;
      repeat (20) @(posedge clk);
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      check("count held in pause", rd, held);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 8'h00);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 8'h08);
      apb(1'b0, ctm_pkg::ADDR_CNT_LO, 8'h00);
      check("count zeroed on enable", rd >> 4, 32'h0);
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_pinfn();
      t_cmp_a();
      t_clear_p();
      t_timer();
      t_pwm();
      t_pause();
      end_of_test();
   end
   // Whole run needs a few thousand cycles; this limit leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule
